// ===== inc/vsf_pkg.sv
package vsf_pkg;

   // ****************************************
   // operating phases
   // ****************************************
   typedef enum logic [1:0] {
      ST_PRECHARGE,
      ST_SOFT_START,
      ST_RUN,
      ST_LATCHED
   } phase_t;

   // feedback comparator results
   typedef struct packed {
      logic above_reset;
      logic above_down;
      logic above_up;
   } fb_cmp_t;

   // valley-sense comparator results
   typedef struct packed {
      logic above_ring_sel;
      logic above_ovp;
      logic above_detect;
   } vs_cmp_t;

endpackage

// ===== inc/vsf_regs.svh
`ifndef VSF_REGS_SVH
`define VSF_REGS_SVH

// ****************************************
// clock and timing figures
// ****************************************
`define VSF_CLK_KHZ          125000
`define VSF_SS_TIME_MS       12
`define VSF_SS_STEPS         4
`define VSF_EVAL_TIME_MS     48
`define VSF_TOFF_MAX_US      45
`define VSF_RS_SHORT_NS      1000
`define VSF_RS_LONG_NS       2500
`define VSF_OVP_BLANK_NS     2000

// ****************************************
// derived cycle counts
// ****************************************
`define VSF_SS_STEP_CYC   ((`VSF_SS_TIME_MS * `VSF_CLK_KHZ) / `VSF_SS_STEPS)
`define VSF_EVAL_CYC      (`VSF_EVAL_TIME_MS * `VSF_CLK_KHZ)
`define VSF_TOFF_MAX_CYC  ((`VSF_TOFF_MAX_US * `VSF_CLK_KHZ) / 1000)
`define VSF_RS_SHORT_CYC  ((`VSF_RS_SHORT_NS * `VSF_CLK_KHZ + 999999) / 1000000)
`define VSF_RS_LONG_CYC   ((`VSF_RS_LONG_NS * `VSF_CLK_KHZ + 999999) / 1000000)
`define VSF_OVP_BLANK_CYC ((`VSF_OVP_BLANK_NS * `VSF_CLK_KHZ + 999999) / 1000000)

// ****************************************
// counter limits and levels
// ****************************************
`define VSF_UD_MIN        3'h1
`define VSF_UD_MAX        3'h7
`define VSF_VC_MAX        3'h7
`define VSF_SS_LAST_STEP  2'h3
// current-sense peak limit in mV: 320, step 227, final 1000
`define VSF_CS_START_MV   10'h140
`define VSF_CS_STEP_MV    10'h0E3
`define VSF_CS_FINAL_MV   10'h3E8

`endif

// ===== logic/valley_counter.sv
`timescale 1ns/1ps
`default_nettype none

`include "vsf_regs.svh"

module valley_counter
   import vsf_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       gate_high,
   input  wire logic       above_detect,
   output logic [2:0]      valley_count_r
);

   logic       detect_prev_r;
   logic       detect_prev_nxt;
   logic [2:0] count_nxt;
   logic       falling;

   // ****************************************
   // crossing count
   // ****************************************
   assign falling = detect_prev_r & ~above_detect;

   // clear while driven, count falling crossings while off
   always_comb begin
      detect_prev_nxt = above_detect;
      count_nxt       = valley_count_r;
      if (gate_high) begin
         count_nxt = 3'h0;
      end else if (falling && valley_count_r != `VSF_VC_MAX) begin
         count_nxt = valley_count_r + 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         detect_prev_r  <= 1'b0;
         valley_count_r <= 3'h0;
      end else begin
         detect_prev_r  <= detect_prev_nxt;
         valley_count_r <= count_nxt;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   AST_VC_CLEAR: assert property (gate_high |=> valley_count_r == 3'h0)
      else $error("valley count not cleared while gate high");
   AST_VC_INC: assert property (!gate_high && falling && valley_count_r != 3'h7
      |=> valley_count_r == $past(valley_count_r) + 3'h1)
      else $error("valley count missed a crossing");
   AST_VC_SAT: assert property (valley_count_r == 3'h7 && !gate_high
      |=> valley_count_r == 3'h7)
      else $error("valley count left saturation");

endmodule

`default_nettype wire

// ===== logic/valley_switch_frequency_reduction.sv
`timescale 1ns/1ps
`default_nettype none

`include "vsf_regs.svh"

module valley_switch_frequency_reduction
   import vsf_pkg::*;
#(
   parameter int unsigned SS_STEP_CYC   = `VSF_SS_STEP_CYC,
   parameter int unsigned EVAL_CYC      = `VSF_EVAL_CYC,
   parameter int unsigned TOFF_MAX_CYC  = `VSF_TOFF_MAX_CYC,
   parameter int unsigned RS_SHORT_CYC  = `VSF_RS_SHORT_CYC,
   parameter int unsigned RS_LONG_CYC   = `VSF_RS_LONG_CYC,
   parameter int unsigned OVP_BLANK_CYC = `VSF_OVP_BLANK_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       supply_above_on,
   input  wire fb_cmp_t    fb_cmp,
   input  wire vs_cmp_t    vs_cmp,
   input  wire logic       switch_off_req,
   input  wire logic [1:0] line_level,
   output logic            hv_charger_en_r,
   output logic            soft_start_active_r,
   output logic [9:0]      cs_limit_mv_r,
   output logic [2:0]      updown_count_r,
   output logic [1:0]      fb_thr_sel_r,
   output logic            gate_drive_r,
   output logic            latched_off_r
);

   // ****************************************
   // declarations
   // ****************************************
   phase_t      phase_r;
   phase_t      phase_nxt;
   logic [31:0] ss_cnt_r;
   logic [31:0] ss_cnt_nxt;
   logic [1:0]  ss_step_r;
   logic [1:0]  ss_step_nxt;
   logic [31:0] eval_cnt_r;
   logic [31:0] eval_cnt_nxt;
   fb_cmp_t     flags_r;
   fb_cmp_t     flags_nxt;
   fb_cmp_t     seen;
   logic [2:0]  ud_nxt;
   logic [31:0] rs_cnt_r;
   logic [31:0] rs_cnt_nxt;
   logic [31:0] off_cnt_r;
   logic [31:0] off_cnt_nxt;
   logic [31:0] ovp_cnt_r;
   logic [31:0] ovp_cnt_nxt;
   logic        gate_nxt;
   logic [2:0]  valley_count;
   logic        running;
   logic        eval_end;
   logic        valley_ok;
   logic        off_max;
   logic        ovp_trip;

   // peak limit for a soft-start step
   function automatic logic [9:0] cs_level(input phase_t ph, input logic [1:0] step);
      logic [9:0] lvl;
      lvl = `VSF_CS_START_MV + 10'(step) * `VSF_CS_STEP_MV;
      if (ph == ST_RUN || step == `VSF_SS_LAST_STEP) begin
         lvl = `VSF_CS_FINAL_MV;
      end
      return lvl;
   endfunction

   // ****************************************
   // shared conditions
   // ****************************************
   assign running   = (phase_r == ST_SOFT_START) || (phase_r == ST_RUN);
   assign eval_end  = running && (eval_cnt_r == EVAL_CYC - 1);
   assign seen      = flags_r | fb_cmp;
   assign valley_ok = (rs_cnt_r == 32'h0) && (valley_count >= updown_count_r);
   assign off_max   = (off_cnt_r == TOFF_MAX_CYC - 1);
   assign ovp_trip  = running && !gate_drive_r && vs_cmp.above_ovp
                      && (ovp_cnt_r == OVP_BLANK_CYC - 1);

   // ****************************************
   // start-up and soft-start
   // ****************************************
   // phase sequencing and step timer
   always_comb begin
      phase_nxt   = phase_r;
      ss_cnt_nxt  = ss_cnt_r;
      ss_step_nxt = ss_step_r;
      case (phase_r)
         ST_PRECHARGE: begin
            if (supply_above_on) begin
               phase_nxt   = ST_SOFT_START;
               ss_cnt_nxt  = 32'h0;
               ss_step_nxt = 2'h0;
            end
         end
         ST_SOFT_START: begin
            if (ss_cnt_r == SS_STEP_CYC - 1) begin
               ss_cnt_nxt = 32'h0;
               if (ss_step_r == `VSF_SS_LAST_STEP) begin
                  phase_nxt = ST_RUN;
               end else begin
                  ss_step_nxt = ss_step_r + 2'h1;
               end
            end else begin
               ss_cnt_nxt = ss_cnt_r + 32'h1;
            end
         end
         ST_RUN: begin
            ss_cnt_nxt = 32'h0;
         end
         ST_LATCHED: begin
            ss_cnt_nxt = 32'h0;
         end
         default: begin
            phase_nxt = ST_PRECHARGE;
         end
      endcase
      if (ovp_trip) begin
         phase_nxt = ST_LATCHED;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         phase_r             <= ST_PRECHARGE;
         ss_cnt_r            <= 32'h0;
         ss_step_r           <= 2'h0;
         hv_charger_en_r     <= 1'b1;
         soft_start_active_r <= 1'b0;
         cs_limit_mv_r       <= `VSF_CS_START_MV;
         latched_off_r       <= 1'b0;
         fb_thr_sel_r        <= 2'h0;
      end else begin
         phase_r             <= phase_nxt;
         ss_cnt_r            <= ss_cnt_nxt;
         ss_step_r           <= ss_step_nxt;
         hv_charger_en_r     <= (phase_nxt == ST_PRECHARGE);
         soft_start_active_r <= (phase_nxt == ST_SOFT_START);
         cs_limit_mv_r       <= cs_level(phase_nxt, ss_step_nxt);
         latched_off_r       <= (phase_nxt == ST_LATCHED);
         fb_thr_sel_r        <= line_level;
      end
   end

   // ****************************************
   // up/down counter
   // ****************************************
   // period timer, sticky flags and counter update
   always_comb begin
      ud_nxt       = updown_count_r;
      eval_cnt_nxt = eval_cnt_r + 32'h1;
      flags_nxt    = seen;
      if (!running) begin
         eval_cnt_nxt = 32'h0;
         flags_nxt    = fb_cmp_t'(3'h0);
         if (phase_r == ST_PRECHARGE) begin
            ud_nxt = `VSF_UD_MIN;
         end
      end else if (eval_end) begin
         eval_cnt_nxt = 32'h0;
         flags_nxt    = fb_cmp_t'(3'h0);
         if (seen.above_reset) begin
            ud_nxt = `VSF_UD_MIN;
         end else if (seen.above_down) begin
            if (updown_count_r > `VSF_UD_MIN) begin
               ud_nxt = updown_count_r - 3'h1;
            end
         end else if (!seen.above_up) begin
            if (updown_count_r < `VSF_UD_MAX) begin
               ud_nxt = updown_count_r + 3'h1;
            end
         end
         // above up only: value kept
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         updown_count_r <= `VSF_UD_MIN;
         eval_cnt_r     <= 32'h0;
         flags_r        <= fb_cmp_t'(3'h0);
      end else begin
         updown_count_r <= ud_nxt;
         eval_cnt_r     <= eval_cnt_nxt;
         flags_r        <= flags_nxt;
      end
   end

   // ****************************************
   // valley counting
   // ****************************************
   valley_counter u_valley_counter (
      .sys_clk        (sys_clk),
      .srst           (srst),
      .gate_high      (gate_drive_r),
      .above_detect   (vs_cmp.above_detect),
      .valley_count_r (valley_count)
   );

   // ****************************************
   // switch-on control and protection
   // ****************************************
   // gate state, ring suppression, off-time and overvoltage timers
   always_comb begin
      gate_nxt    = gate_drive_r;
      rs_cnt_nxt  = (rs_cnt_r != 32'h0) ? rs_cnt_r - 32'h1 : 32'h0;
      off_cnt_nxt = 32'h0;
      ovp_cnt_nxt = 32'h0;
      if (!running || ovp_trip) begin
         gate_nxt   = 1'b0;
         rs_cnt_nxt = 32'h0;
      end else if (gate_drive_r) begin
         if (switch_off_req) begin
            gate_nxt   = 1'b0;
            rs_cnt_nxt = vs_cmp.above_ring_sel ? RS_SHORT_CYC : RS_LONG_CYC;
         end
      end else begin
         off_cnt_nxt = off_cnt_r + 32'h1;
         if (vs_cmp.above_ovp) begin
            ovp_cnt_nxt = ovp_cnt_r + 32'h1;
         end
         if (valley_ok || off_max) begin
            gate_nxt    = 1'b1;
            off_cnt_nxt = 32'h0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gate_drive_r <= 1'b0;
         rs_cnt_r     <= 32'h0;
         off_cnt_r    <= 32'h0;
         ovp_cnt_r    <= 32'h0;
      end else begin
         gate_drive_r <= gate_nxt;
         rs_cnt_r     <= rs_cnt_nxt;
         off_cnt_r    <= off_cnt_nxt;
         ovp_cnt_r    <= ovp_cnt_nxt;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   AST_START_HANDOVER: assert property (
      phase_r == ST_PRECHARGE && supply_above_on
      |=> !hv_charger_en_r && soft_start_active_r)
      else $error("charger not released at turn-on");
   AST_SS_STEP_TIME: assert property (
      phase_r == ST_SOFT_START && $changed(ss_step_r) |-> $past(ss_cnt_r) == SS_STEP_CYC - 1)
      else $error("soft-start step changed off schedule");
   AST_SS_LEVELS: assert property (
      $rose(soft_start_active_r) |-> cs_limit_mv_r == `VSF_CS_START_MV)
      else $error("soft-start did not begin at start level");
   AST_UD_RANGE: assert property (
      updown_count_r >= 3'h1 && updown_count_r <= 3'h7)
      else $error("up/down counter out of range");
   AST_UD_STABLE: assert property (
      running && !eval_end |=> $stable(updown_count_r))
      else $error("up/down counter moved inside a period");
   AST_UD_RESET: assert property (
      eval_end && seen.above_reset |=> updown_count_r == 3'h1)
      else $error("reset threshold did not force counter to one");
   AST_UD_UP: assert property (
      eval_end && seen == fb_cmp_t'(3'h0) && updown_count_r != 3'h7
      |=> updown_count_r == $past(updown_count_r) + 3'h1)
      else $error("counter did not increment");
   AST_UD_DOWN: assert property (
      eval_end && !seen.above_reset && seen.above_down && updown_count_r != 3'h1
      |=> updown_count_r == $past(updown_count_r) - 3'h1)
      else $error("counter did not decrement");
   AST_UD_HOLD: assert property (
      eval_end && seen == fb_cmp_t'(3'h1) |=> $stable(updown_count_r))
      else $error("counter changed in hold band");
   AST_RS_LONG: assert property (
      running && gate_drive_r && switch_off_req && !vs_cmp.above_ring_sel
      |=> rs_cnt_r == RS_LONG_CYC && !gate_drive_r)
      else $error("long suppression time not loaded");
   AST_RS_BLOCK: assert property (
      !gate_drive_r && rs_cnt_r != 32'h0 && !off_max |=> !gate_drive_r)
      else $error("gate rose during ring suppression");
   AST_VALLEY_ON: assert property (
      running && !gate_drive_r && valley_ok && !ovp_trip |=> gate_drive_r)
      else $error("no switch-on at selected valley");
   AST_TOFF_ON: assert property (
      running && !gate_drive_r && off_max && !ovp_trip |=> gate_drive_r)
      else $error("maximum off-time did not force switch-on");
   AST_OVP_LATCH: assert property (
      ovp_trip |=> (latched_off_r && !gate_drive_r)[*4])
      else $error("overvoltage did not latch off");

   COV_SS_DONE: cover property (soft_start_active_r ##1 phase_r == ST_RUN);
   COV_UD_MAX: cover property (updown_count_r == 3'h7);
   COV_TOFF: cover property (!gate_drive_r && off_max ##1 gate_drive_r);
   COV_LATCH: cover property ($rose(latched_off_r));

endmodule

`default_nettype wire

// ===== testbench/switch_partner.sv
`timescale 1ns/1ps
`default_nettype none

module switch_partner
   import vsf_pkg::*;
#(
   parameter int ON_CYC = 3
) (
   input  wire logic sys_clk,
   input  wire logic gate_drive_r,
   input  wire logic ring_en,
   input  wire logic ring_sel,
   input  wire logic ovp_en,
   output logic      switch_off_req,
   output vs_cmp_t   vs_cmp
);
   int         on_cnt;
   logic [1:0] phase;

   // quiet start: switch off, winding flat
   initial begin
      on_cnt = 0;
      phase = 2'h0;
      switch_off_req = 1'b0;
      vs_cmp = '0;
   end

   // peak current trip after ON_CYC, ringing while off
   always @(negedge sys_clk) begin
      vs_cmp.above_ring_sel = ring_sel;
      if (gate_drive_r) begin
         on_cnt = on_cnt + 1;
         phase = 2'h0;
         switch_off_req = (on_cnt >= ON_CYC);
         vs_cmp.above_detect = 1'b0;
         vs_cmp.above_ovp = 1'b0;
      end else begin
         on_cnt = 0;
         phase = phase + 2'h1;
         switch_off_req = 1'b0;
         vs_cmp.above_detect = ring_en & ~phase[1]; // falling edge every 4 cycles
         vs_cmp.above_ovp = ovp_en;
      end
   end
endmodule

`default_nettype wire

// ===== testbench/valley_switch_frequency_reduction_tb.sv
`timescale 1ns/1ps
`default_nettype none

module valley_switch_frequency_reduction_tb
   import vsf_pkg::*;
;
   localparam int SS  = 20;
   localparam int EV  = 40;
   localparam int TO  = 60;
   localparam int RSS = 3;
   localparam int RSL = 6;

   logic       sys_clk;
   logic       srst;
   logic       supply_above_on;
   fb_cmp_t    fb_cmp;
   vs_cmp_t    vs_cmp;
   logic       switch_off_req;
   logic [1:0] line_level;
   logic       hv_charger_en_r;
   logic       soft_start_active_r;
   logic [9:0] cs_limit_mv_r;
   logic [2:0] updown_count_r;
   logic [1:0] fb_thr_sel_r;
   logic       gate_drive_r;
   logic       latched_off_r;
   logic       ring_en;
   logic       ring_sel;
   logic       ovp_en;
   int         fail_count;
   int         samples_checked;

   valley_switch_frequency_reduction #(
      .SS_STEP_CYC  (SS),
      .EVAL_CYC     (EV),
      .TOFF_MAX_CYC (TO),
      .RS_SHORT_CYC (RSS),
      .RS_LONG_CYC  (RSL),
      .OVP_BLANK_CYC(4)
   ) u_valley_switch_frequency_reduction (
      .sys_clk            (sys_clk),
      .srst               (srst),
      .supply_above_on    (supply_above_on),
      .fb_cmp             (fb_cmp),
      .vs_cmp             (vs_cmp),
      .switch_off_req     (switch_off_req),
      .line_level         (line_level),
      .hv_charger_en_r    (hv_charger_en_r),
      .soft_start_active_r(soft_start_active_r),
      .cs_limit_mv_r      (cs_limit_mv_r),
      .updown_count_r     (updown_count_r),
      .fb_thr_sel_r       (fb_thr_sel_r),
      .gate_drive_r       (gate_drive_r),
      .latched_off_r      (latched_off_r)
   );

   switch_partner u_switch_partner (
      .sys_clk       (sys_clk),
      .gate_drive_r  (gate_drive_r),
      .ring_en       (ring_en),
      .ring_sel      (ring_sel),
      .ovp_en        (ovp_en),
      .switch_off_req(switch_off_req),
      .vs_cmp        (vs_cmp)
   );

   // 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   task automatic summarize();
      $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk_reset();
      check("hv_en", 10'h001, 10'(hv_charger_en_r));
      check("ss_act", 10'h000, 10'(soft_start_active_r));
      check("cs_lim", 10'h140, cs_limit_mv_r);
      check("updown", 10'h001, 10'(updown_count_r));
      check("gate", 10'h000, 10'(gate_drive_r));
      check("latch", 10'h000, 10'(latched_off_r));
   endtask

   task automatic do_reset();
      @(negedge sys_clk);
      srst = 1'b1;
      supply_above_on = 1'b0;
      ovp_en = 1'b0;
      repeat (4) @(negedge sys_clk);
      srst = 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
      chk_reset();
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic thr_select();
      for (int k = 0; k < 4; k++) begin
         @(negedge sys_clk);
         line_level = 2'(k);
         @(posedge sys_clk);
         #1;
         check("thr_sel", 10'(k), 10'(fb_thr_sel_r));
      end
   endtask

   task automatic soft_start();
      logic [9:0] exp_cs [4] = '{10'h223, 10'h306, 10'h3E8, 10'h3E8};
      @(negedge sys_clk);
      supply_above_on = 1'b1;
      // handover edge; later checks land just after each step and period edge
      @(posedge sys_clk);
      #1;
      check("hv_en", 10'h000, 10'(hv_charger_en_r));
      check("ss_act", 10'h001, 10'(soft_start_active_r));
      check("cs_lim", 10'h140, cs_limit_mv_r);
      for (int k = 0; k < 4; k++) begin
         repeat (SS) @(posedge sys_clk);
         #1;
         check("cs_lim", exp_cs[k], cs_limit_mv_r);
      end
      check("ss_act", 10'h000, 10'(soft_start_active_r));
      check("updown", 10'h003, 10'(updown_count_r));
   endtask

   task automatic updown_seq();
      logic [2:0] fbs [12] = '{0, 0, 0, 0, 0, 1, 3, 3, 7, 3, 3, 7};
      logic [2:0] exps [12] = '{4, 5, 6, 7, 7, 7, 6, 5, 1, 1, 1, 1};
      for (int k = 0; k < 12; k++) begin
         @(negedge sys_clk);
         fb_cmp = fb_cmp_t'(fbs[k]);
         repeat (EV) @(posedge sys_clk);
         #1;
         check("updown", 10'(exps[k]), 10'(updown_count_r));
      end
   endtask

   task automatic wait_gate(input logic lvl);
      int n;
      n = 0;
      while (gate_drive_r !== lvl && n < 200) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      check("gate", 10'(lvl), 10'(gate_drive_r));
   endtask

   task automatic off_time(input logic ring, input logic sel, input int lo, input int hi);
      int n;
      @(negedge sys_clk);
      ring_en = ring;
      ring_sel = sel;
      wait_gate(1'b1);
      wait_gate(1'b0);
      n = 0;
      while (gate_drive_r === 1'b0 && n < 200) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      samples_checked++;
      if (n < lo || n > hi) begin
         fail_count++;
         $display("CHECK FAILED off_time expected %0d..%0d seen %0d", lo, hi, n);
      end
   endtask

   task automatic gate_timing();
      off_time(1'b1, 1'b1, RSS, RSS + 2);
      off_time(1'b1, 1'b0, RSL, RSL + 2);
      off_time(1'b0, 1'b1, TO - 2, TO + 2);
   endtask

   task automatic ovp_latch();
      int n;
      @(negedge sys_clk);
      ovp_en = 1'b1;
      n = 0;
      while (latched_off_r !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      check("latch", 10'h001, 10'(latched_off_r));
      // gate just rose: 3 on-cycles, then 4 blanking cycles of overvoltage
      check("blank", 10'h007, 10'(n));
      repeat (2 * TO) @(posedge sys_clk);
      #1;
      check("gate", 10'h000, 10'(gate_drive_r));
      check("latch", 10'h001, 10'(latched_off_r));
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      fail_count = 0;
      samples_checked = 0;
      srst = 1'b1;
      supply_above_on = 1'b0;
      fb_cmp = '0;
      line_level = 2'h0;
      ring_en = 1'b1;
      ring_sel = 1'b1;
      ovp_en = 1'b0;
      do_reset();
      thr_select();
      soft_start();
      updown_seq();
      gate_timing();
      ovp_latch();
      do_reset();
      summarize();
   end

   // watchdog against a hang
   initial begin
      #40000;
      fail_count++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      summarize();
   end
endmodule

`default_nettype wire
